// ===== src/ihw_ctrl.v
// interrupt entry/return sequencing and halt/wake-up control for a 4-bit core
// assumes the core sequencer shares i_mclk and drives its strobes as one-cycle pulses
//
// What this block does
// - a taken interrupt forces the program counter to the one entry address 0x0008.
// - the request recurs at 32768 Hz, or at 65536 Hz with the double-rate option.
// - with the global enable high and the flag set, the interrupt is taken on the next clock.
// - on entry the next pc, page high, address high, carry and zero are saved in one clock.
// - entering service clears the global enable.
// - the request flag stays set after entry and only a software write clears it.
// - the return instruction restores the saved state and sets the global enable.
// - there is one shadow set, so no second entry happens before the return.
// - the core runs from the main clock in normal mode and HALT moves it to halt mode.
// - halt stops pc and core clock, and software cannot change mode until wake or reset.
// - a rising edge on any pin of ports A, B or E wakes the core from halt.
// - HALT puts 0x0004 on the pc on the next clock, and after a wake it waits 64 clocks to advance.
// - reset overrides wake, puts 0x0000 on the pc and waits 64 clocks before advancing.
// - working SRAM is left untouched during halt and across the wake-up.
// - each completed audio output cycle sets the request flag.
// - HALT clears the audio output enable, stopping the periodic request.
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "ihw_consts.vh"

module ihw_ctrl #(
  parameter P_DOUBLE_RATE_IRQ_OPTION = 0,
  parameter P_IRQ_PERIOD_CYC         = (P_DOUBLE_RATE_IRQ_OPTION != 0) ?
                                       (`IHW_CLK_HZ / `IHW_IRQ_RATE2_HZ) :
                                       (`IHW_CLK_HZ / `IHW_IRQ_RATE_HZ)
) (
  input  wire                  i_mclk,
  input  wire                  i_rst,
  // ahb-lite slave
  input  wire                  i_hsel,
  input  wire [31:0]           i_haddr,
  input  wire [1:0]            i_htrans,
  input  wire                  i_hwrite,
  input  wire [2:0]            i_hsize,
  input  wire [31:0]           i_hwdata,
  input  wire                  i_hready,
  output wire [31:0]           o_hrdata,
  output wire                  o_hreadyout,
  output wire                  o_hresp,
  // core sequencer
  input  wire [`IHW_PC_W-1:0]  i_next_pc,
  input  wire [3:0]            i_data_page_high,
  input  wire [3:0]            i_memory_addr_high,
  input  wire                  i_carry_flag,
  input  wire                  i_zero_flag,
  input  wire                  i_exec_return_from_irq,
  input  wire                  i_exec_halt,
  output wire                  o_pc_load,
  output wire [`IHW_PC_W-1:0]  o_pc_load_addr,
  output wire                  o_pc_hold,
  output wire                  o_core_clk_en,
  output wire                  o_sram_write_block,
  output wire                  o_restore,
  output wire [3:0]            o_restore_data_page_high,
  output wire [3:0]            o_restore_memory_addr_high,
  output wire                  o_restore_carry,
  output wire                  o_restore_zero,
  output wire                  o_flag_write,
  output wire [1:0]            o_flag_write_data,
  output wire                  o_audio_output_enable,
  output wire                  o_audio_request,
  // wake-up pins
  input  wire [3:0]            i_port_a_pins,
  input  wire [3:0]            i_port_b_pins,
  input  wire [3:0]            i_port_e_pins
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  localparam ST_RUN  = 4'h1;
  localparam ST_HALT = 4'h2;
  localparam ST_WAKE = 4'h4;
  localparam ST_RSTW = 4'h8;

  localparam integer PERIOD_LAST_I = P_IRQ_PERIOD_CYC - 1, STABLE_LAST_I = `IHW_STABLE_CYC - 1;
  localparam [`IHW_PERIOD_W-1:0] PERIOD_LAST = PERIOD_LAST_I[`IHW_PERIOD_W-1:0];
  localparam [`IHW_STABLE_W-1:0] STABLE_LAST = STABLE_LAST_I[`IHW_STABLE_W-1:0];

  reg  [3:0]                state_ff;
  reg  [3:0]                nxt_state;
  reg  [`IHW_STABLE_W-1:0]  stable_cnt_ff;
  reg  [`IHW_PERIOD_W-1:0]  period_cnt_ff;

  reg                       req_flag_ff;
  reg                       gie_ff;
  reg                       audio_en_ff;
  reg                       in_service_ff;

  reg  [`IHW_PC_W-1:0]      sh_pc_ff;
  reg  [3:0]                sh_page_ff;
  reg  [3:0]                sh_addr_hi_ff;
  reg                       sh_carry_ff;
  reg                       sh_zero_ff;

  reg                       pc_load_ff;
  reg  [`IHW_PC_W-1:0]      pc_load_addr_ff;
  reg                       restore_ff;
  reg                       flag_wr_ff;
  reg  [1:0]                flag_wr_data_ff;

  reg                       wr_pend_ff;
  reg  [`IHW_IDX_W-1:0]     wr_idx_ff;
  reg  [31:0]               rdata_ff;
  reg  [31:0]               nxt_rdata;

  wire                      pin_rise;
  wire                      running;
  wire                      audio_done;
  wire                      take_irq;
  wire                      do_return;
  wire                      do_halt;
  wire                      bus_req;
  wire [`IHW_IDX_W-1:0]     addr_idx;
  wire                      sw_wr;
  wire                      wr_status;
  wire                      wr_ctrl;

  //////////////////////////////////////////////////////////////////////////////
  // wake-up pin edges

  ihw_edge_sync #(
    .W (12)
  ) u_wake_sync (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .i_pins     ({i_port_e_pins, i_port_b_pins, i_port_a_pins}),
    .o_any_rise (pin_rise)
  );

  //////////////////////////////////////////////////////////////////////////////
  // core events

  assign running    = (state_ff == ST_RUN);
  assign do_halt    = running & i_exec_halt;
  assign do_return  = running & i_exec_return_from_irq & ~do_halt;
  // halt and return outrank entry; the single shadow set blocks nesting
  assign take_irq   = running & gie_ff & req_flag_ff & ~in_service_ff
                      & ~do_halt & ~do_return;
  assign audio_done = audio_en_ff & (period_cnt_ff == PERIOD_LAST);

  //////////////////////////////////////////////////////////////////////////////
  // mode state machine

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (do_halt)
          nxt_state = ST_HALT;
      end
      ST_HALT: begin
        if (pin_rise)
          nxt_state = ST_WAKE;
      end
      ST_WAKE: begin
        if (stable_cnt_ff == STABLE_LAST)
          nxt_state = ST_RUN;
      end
      ST_RSTW: begin
        if (stable_cnt_ff == STABLE_LAST)
          nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_RSTW;
      end
    endcase
  end

  // reset always lands in the reset wait, so it wins over any pending wake
  always @(posedge i_mclk) begin
    if (i_rst) begin
      state_ff      <= ST_RSTW;
      stable_cnt_ff <= {`IHW_STABLE_W{1'b0}};
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_WAKE || state_ff == ST_RSTW)
        stable_cnt_ff <= stable_cnt_ff + 1'b1;
      else
        stable_cnt_ff <= {`IHW_STABLE_W{1'b0}};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // periodic audio request source

  // integer division rounds the period down, so the rate sits slightly high
  always @(posedge i_mclk) begin
    if (i_rst) begin
      period_cnt_ff <= {`IHW_PERIOD_W{1'b0}};
    end else if (!audio_en_ff || audio_done) begin
      period_cnt_ff <= {`IHW_PERIOD_W{1'b0}};
    end else begin
      period_cnt_ff <= period_cnt_ff + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, always okay

  assign bus_req     = i_hsel & i_htrans[1] & i_hready;
  assign addr_idx    = i_haddr[`IHW_IDX_W+1:2];
  assign sw_wr       = wr_pend_ff;
  assign wr_status   = sw_wr & (wr_idx_ff == `IHW_IDX_CORE_STATUS_FLAGS);
  // writes to the control register are dropped unless the core is running
  assign wr_ctrl     = sw_wr & (wr_idx_ff == `IHW_IDX_AUDIO_IRQ_CONTROL) & running;

  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (addr_idx)
      `IHW_IDX_CORE_STATUS_FLAGS: begin
        nxt_rdata[`IHW_ST_REQ_BIT]   = req_flag_ff;
        nxt_rdata[`IHW_ST_CARRY_BIT] = i_carry_flag;
        nxt_rdata[`IHW_ST_ZERO_BIT]  = i_zero_flag;
      end
      `IHW_IDX_AUDIO_IRQ_CONTROL: begin
        nxt_rdata[`IHW_CT_GIE_BIT]      = gie_ff;
        nxt_rdata[`IHW_CT_AUDIO_EN_BIT] = audio_en_ff;
      end
      `IHW_IDX_MODE_STATUS: begin
        nxt_rdata[`IHW_MS_IN_SERVICE_BIT] = in_service_ff;
        nxt_rdata[`IHW_MS_HALT_BIT]       = (state_ff == ST_HALT);
        nxt_rdata[`IHW_MS_WAKE_WAIT_BIT]  = (state_ff == ST_WAKE);
        nxt_rdata[`IHW_MS_RESET_WAIT_BIT] = (state_ff == ST_RSTW);
      end
      default: begin
        nxt_rdata = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge i_mclk) begin
    if (i_rst) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= {`IHW_IDX_W{1'b0}};
      rdata_ff   <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= bus_req & i_hwrite;
      if (bus_req) begin
        wr_idx_ff <= addr_idx;
        rdata_ff  <= i_hwrite ? 32'h0000_0000 : nxt_rdata;
      end
    end
  end

  assign o_hrdata    = rdata_ff;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // flags and enables

  always @(posedge i_mclk) begin
    if (i_rst) begin
      req_flag_ff   <= `IHW_RST_REQ_FLAG;
      gie_ff        <= `IHW_RST_GIE;
      audio_en_ff   <= `IHW_RST_AUDIO_EN;
      in_service_ff <= 1'b0;
    end else begin
      // hardware set wins over a software clear in the same cycle
      if (audio_done)
        req_flag_ff <= 1'b1;
      else if (wr_status)
        req_flag_ff <= i_hwdata[`IHW_ST_REQ_BIT];

      if (take_irq)
        gie_ff <= 1'b0;
      else if (do_return)
        gie_ff <= 1'b1;
      else if (wr_ctrl)
        gie_ff <= i_hwdata[`IHW_CT_GIE_BIT];

      if (do_halt)
        audio_en_ff <= 1'b0;
      else if (wr_ctrl)
        audio_en_ff <= i_hwdata[`IHW_CT_AUDIO_EN_BIT];

      if (take_irq)
        in_service_ff <= 1'b1;
      else if (do_return)
        in_service_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // shadow registers and pc control

  always @(posedge i_mclk) begin
    if (i_rst) begin
      sh_pc_ff      <= {`IHW_PC_W{1'b0}};
      sh_page_ff    <= 4'h0;
      sh_addr_hi_ff <= 4'h0;
      sh_carry_ff   <= 1'b0;
      sh_zero_ff    <= 1'b0;
    end else if (take_irq) begin
      sh_pc_ff      <= i_next_pc;
      sh_page_ff    <= i_data_page_high;
      sh_addr_hi_ff <= i_memory_addr_high;
      sh_carry_ff   <= i_carry_flag;
      sh_zero_ff    <= i_zero_flag;
    end
  end

  // restored pc rides the same load strobe as the vectors
  always @(posedge i_mclk) begin
    if (i_rst) begin
      pc_load_ff      <= 1'b1;
      pc_load_addr_ff <= `IHW_VEC_RESET;
      restore_ff      <= 1'b0;
      flag_wr_ff      <= 1'b0;
      flag_wr_data_ff <= 2'b00;
    end else begin
      restore_ff      <= do_return;
      flag_wr_ff      <= wr_status;
      flag_wr_data_ff <= i_hwdata[`IHW_ST_CARRY_BIT:`IHW_ST_ZERO_BIT];
      if (do_halt) begin
        pc_load_ff      <= 1'b1;
        pc_load_addr_ff <= `IHW_VEC_WAKEUP;
      end else if (take_irq) begin
        pc_load_ff      <= 1'b1;
        pc_load_addr_ff <= `IHW_VEC_IRQ;
      end else if (do_return) begin
        pc_load_ff      <= 1'b1;
        pc_load_addr_ff <= sh_pc_ff;
      end else begin
        pc_load_ff      <= (nxt_state != ST_RUN);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_pc_load                  = pc_load_ff;
  assign o_pc_load_addr             = pc_load_addr_ff;
  assign o_pc_hold                  = ~running;
  // core clock only in run; the wait states keep it gated until stable
  assign o_core_clk_en              = running;
  // sram contents are frozen whenever the core is not running
  assign o_sram_write_block         = ~running;
  assign o_restore                  = restore_ff;
  assign o_restore_data_page_high   = sh_page_ff;
  assign o_restore_memory_addr_high = sh_addr_hi_ff;
  assign o_restore_carry            = sh_carry_ff;
  assign o_restore_zero             = sh_zero_ff;
  assign o_flag_write               = flag_wr_ff;
  assign o_flag_write_data          = flag_wr_data_ff;
  assign o_audio_output_enable      = audio_en_ff;
  assign o_audio_request            = req_flag_ff;

endmodule

// ===== src/ihw_consts.vh
// constants for the interrupt entry/return and halt/wake-up controller
// assumes a 200 MHz system clock and word-aligned AHB-Lite register access
`ifndef IHW_CONSTS_VH
`define IHW_CONSTS_VH

// register indices as printed; byte address is four times the index
`define IHW_IDX_CORE_STATUS_FLAGS   8'h00
`define IHW_IDX_AUDIO_IRQ_CONTROL   8'h09
`define IHW_IDX_MODE_STATUS         8'h20
`define IHW_IDX_W                   8

// core status flags fields
`define IHW_ST_ZERO_BIT             0
`define IHW_ST_CARRY_BIT            1
`define IHW_ST_REQ_BIT              2
// audio irq control fields
`define IHW_CT_AUDIO_EN_BIT         0
`define IHW_CT_GIE_BIT              1
// mode status fields
`define IHW_MS_IN_SERVICE_BIT       0
`define IHW_MS_HALT_BIT             1
`define IHW_MS_WAKE_WAIT_BIT        2
`define IHW_MS_RESET_WAIT_BIT       3

// reset values
`define IHW_RST_REQ_FLAG            1'b0
`define IHW_RST_GIE                 1'b0
`define IHW_RST_AUDIO_EN            1'b0

// program addresses
`define IHW_PC_W                    13
`define IHW_VEC_RESET               13'h0000
`define IHW_VEC_WAKEUP              13'h0004
`define IHW_VEC_IRQ                 13'h0008

// timing
`define IHW_CLK_HZ                  200000000
`define IHW_IRQ_RATE_HZ             32768
`define IHW_IRQ_RATE2_HZ            65536
`define IHW_PERIOD_W                13
`define IHW_STABLE_CYC              64
`define IHW_STABLE_W                7

`endif

// ===== src/ihw_edge_sync.v
// two-flop synchroniser and rising-edge detector for a group of pins
// assumes pins are asynchronous to i_mclk; output is a registered pulse on a rising edge of any pin
`timescale 1ns/1ps

module ihw_edge_sync #(
  parameter W = 12
) (
  input  wire         i_mclk,
  input  wire         i_rst,
  input  wire [W-1:0] i_pins,
  output wire         o_any_rise
);

  reg [W-1:0] sync1_ff;
  reg [W-1:0] sync2_ff;
  reg [W-1:0] last_ff;
  reg         rise_ff;

  always @(posedge i_mclk) begin
    if (i_rst) begin
      sync1_ff <= {W{1'b0}};
      sync2_ff <= {W{1'b0}};
      last_ff  <= {W{1'b0}};
      rise_ff  <= 1'b0;
    end else begin
      sync1_ff <= i_pins;
      sync2_ff <= sync1_ff;
      last_ff  <= sync2_ff;
      // only the second stage feeds the detector
      rise_ff  <= |(sync2_ff & ~last_ff);
    end
  end

  assign o_any_rise = rise_ff;

endmodule

// ===== verif/ihw_ctrl_assertions.sv
// port-level checks for the irq entry/return and halt/wake controller
// bound to ihw_ctrl; sees only its ports, one clock domain
`timescale 1ns/1ps
`include "ihw_consts.vh"

module ihw_ctrl_chk #(
  parameter P_IRQ_PERIOD_CYC = 16
) (
  input wire                 i_mclk,
  input wire                 i_rst,
  input wire [`IHW_PC_W-1:0] i_next_pc,
  input wire                 i_exec_return_from_irq,
  input wire                 i_exec_halt,
  input wire                 o_pc_load,
  input wire [`IHW_PC_W-1:0] o_pc_load_addr,
  input wire                 o_pc_hold,
  input wire                 o_core_clk_en,
  input wire                 o_sram_write_block,
  input wire                 o_restore,
  input wire                 o_flag_write,
  input wire                 o_audio_output_enable,
  input wire                 o_audio_request
);
  // two cycles of slack for the enable and flag registers
  localparam int AUD_MAX = P_IRQ_PERIOD_CYC + 2;
  wire                entry = o_pc_load && o_core_clk_en && !o_restore;
  reg [7:0]           off_ff = 8'h00;
  reg [15:0]          aud_ff = 16'h0000;
  reg                 svc_ff = 1'b0;
  reg [`IHW_PC_W-1:0] sv_pc_ff;
////////////////////////////////////////////////////////////
  always @(posedge i_mclk) begin
    off_ff <= (i_rst || o_core_clk_en) ? 8'h00 : off_ff + {7'h00, off_ff != 8'hFF};
    aud_ff <= (o_audio_output_enable && !o_audio_request) ? aud_ff + 16'h0001 : 16'h0000;
    svc_ff <= i_rst ? 1'b0 : entry ? 1'b1 : o_restore ? 1'b0 : svc_ff;
    if (entry) begin
      sv_pc_ff <= $past(i_next_pc);
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_entry_pulse;
    o_pc_load_addr == `IHW_VEC_IRQ ##1 !o_pc_load;
  endsequence
  sequence s_wake_hold;
    o_pc_load && o_pc_load_addr == `IHW_VEC_WAKEUP && !o_core_clk_en;
  endsequence
  sequence s_return_load;
    o_restore && o_pc_load && o_pc_load_addr == sv_pc_ff;
  endsequence
  property p_irq_vec; entry |-> s_entry_pulse; endproperty
  property p_irq_cause; entry |-> o_audio_request && $past(o_audio_request); endproperty
  property p_one_level; entry |-> !svc_ff; endproperty
  property p_return;
    o_core_clk_en && i_exec_return_from_irq && !i_exec_halt |=> s_return_load;
  endproperty
  property p_halt; o_core_clk_en && i_exec_halt |=> s_wake_hold and !o_audio_output_enable;
  endproperty
  property p_stopped;
    !o_core_clk_en |-> o_pc_load && o_pc_hold && o_sram_write_block &&
      (o_pc_load_addr == `IHW_VEC_RESET || o_pc_load_addr == `IHW_VEC_WAKEUP);
  endproperty
  property p_run; o_core_clk_en |-> !o_pc_hold && !o_sram_write_block; endproperty
  property p_wait64; $rose(o_core_clk_en) |-> off_ff >= 8'h40; endproperty
  property p_reset_vec; $fell(i_rst) |-> o_pc_load && o_pc_load_addr == `IHW_VEC_RESET;
  endproperty
  property p_sticky; $fell(o_audio_request) |-> o_flag_write; endproperty
  property p_aud_rate; aud_ff <= AUD_MAX; endproperty
  a_irq_vec: assert property (p_irq_vec)
    else $error("entry load wrong");
  a_irq_cause: assert property (p_irq_cause)
    else $error("entry without request");
  a_one_level: assert property (p_one_level)
    else $error("nested entry");
  a_return: assert property (p_return)
    else $error("return load wrong");
  a_halt: assert property (p_halt)
    else $error("halt entry wrong");
  a_stopped: assert property (p_stopped)
    else $error("stopped outputs wrong");
  a_run: assert property (p_run)
    else $error("run outputs wrong");
  a_wait64: assert property (p_wait64)
    else $error("restart before 64 clocks");
  a_reset_vec: assert property (p_reset_vec)
    else $error("reset load wrong");
  a_sticky: assert property (p_sticky)
    else $error("flag cleared without write");
  a_aud_rate: assert property (p_aud_rate)
    else $error("audio request late");
endmodule

bind ihw_ctrl ihw_ctrl_chk #(.P_IRQ_PERIOD_CYC(P_IRQ_PERIOD_CYC)) u_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_next_pc(i_next_pc),
  .i_exec_return_from_irq(i_exec_return_from_irq), .i_exec_halt(i_exec_halt),
  .o_pc_load(o_pc_load), .o_pc_load_addr(o_pc_load_addr), .o_pc_hold(o_pc_hold),
  .o_core_clk_en(o_core_clk_en), .o_sram_write_block(o_sram_write_block),
  .o_restore(o_restore), .o_flag_write(o_flag_write),
  .o_audio_output_enable(o_audio_output_enable), .o_audio_request(o_audio_request));

// ===== verif/ihw_core_model.sv
// partner model of the core sequencer: pc, core flags and instruction strobes
// assumes it shares clock and reset with ihw_ctrl and obeys its load outputs
`timescale 1ns/1ps
`include "ihw_consts.vh"

module ihw_core_model (
  input  wire                 i_mclk,
  input  wire                 i_rst,
  input  wire                 i_pc_load,
  input  wire [`IHW_PC_W-1:0] i_pc_load_addr,
  input  wire                 i_core_clk_en,
  output wire [`IHW_PC_W-1:0] o_next_pc,
  output logic [3:0]          o_data_page_high,
  output logic [3:0]          o_memory_addr_high,
  output logic                o_carry_flag,
  output logic                o_zero_flag,
  output logic                o_exec_return_from_irq = 1'b0,
  output logic                o_exec_halt = 1'b0
);
  logic [`IHW_PC_W-1:0] pc_ff;
  assign o_next_pc = pc_ff + 13'h0001;
////////////////////////////////////////////////////////////
  // the service routine scrambles the state, so a missed restore shows up
  always @(posedge i_mclk) begin
    if (i_rst) begin
      pc_ff <= `IHW_VEC_RESET;
      {o_data_page_high, o_memory_addr_high, o_carry_flag, o_zero_flag} <= 10'h296;
    end else begin
      if (i_pc_load) begin
        pc_ff <= i_pc_load_addr;
      end else if (i_core_clk_en) begin
        pc_ff <= o_next_pc;
      end
      if (i_pc_load && i_core_clk_en && i_pc_load_addr == `IHW_VEC_IRQ) begin
        {o_data_page_high, o_memory_addr_high, o_carry_flag, o_zero_flag} <= 10'h169;
      end
    end
  end
  task automatic halt;
    @(posedge i_mclk);
    o_exec_halt <= 1'b1;
    @(posedge i_mclk);
    o_exec_halt <= 1'b0;
  endtask
  task automatic ret;
    @(posedge i_mclk);
    o_exec_return_from_irq <= 1'b1;
    @(posedge i_mclk);
    o_exec_return_from_irq <= 1'b0;
  endtask
endmodule

// ===== verif/irq_and_halt_wakeup_control_test.sv
// self-checking bench for the irq entry/return and halt/wake controller
// assumes a 16-cycle audio period and the core model on the sequencer side
`timescale 1ns/1ps
`include "ihw_consts.vh"

module irq_and_halt_wakeup_control_test;
  logic                 i_mclk = 1'b0;
  logic                 i_rst = 1'b1;
  logic                 i_hsel = 1'b0;
  logic [31:0]          i_haddr = 32'h0;
  logic [1:0]           i_htrans = 2'h0;
  logic                 i_hwrite = 1'b0;
  logic [31:0]          i_hwdata = 32'h0;
  logic [11:0]          pins = 12'h000;
  wire [`IHW_PC_W-1:0]  i_next_pc, o_pc_load_addr;
  wire [31:0]           o_hrdata;
  wire [3:0]            i_data_page_high, i_memory_addr_high, rs_pg, rs_ma;
  wire [1:0]            o_flag_write_data;
  wire                  i_carry_flag, i_zero_flag, i_exec_return_from_irq, i_exec_halt;
  wire                  o_hreadyout, o_pc_load, o_pc_hold, o_core_clk_en, o_restore, rs_c, rs_z;
  wire                  o_flag_write, o_audio_output_enable, o_audio_request, o_hresp;
  int                   error_cnt = 0;
  int                   n_checks = 0;
  int                   n;
  logic [31:0]          rd;
  logic [`IHW_PC_W-1:0] pv, pe;
  always #2.5 i_mclk = ~i_mclk;
////////////////////////////////////////////////////////////
  ihw_ctrl #(.P_IRQ_PERIOD_CYC(16)) dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_next_pc(i_next_pc),
    .i_data_page_high(i_data_page_high), .i_memory_addr_high(i_memory_addr_high),
    .i_carry_flag(i_carry_flag), .i_zero_flag(i_zero_flag), .i_exec_halt(i_exec_halt),
    .i_exec_return_from_irq(i_exec_return_from_irq), .o_pc_load(o_pc_load),
    .o_pc_load_addr(o_pc_load_addr), .o_pc_hold(o_pc_hold), .o_core_clk_en(o_core_clk_en),
    .o_sram_write_block(), .o_restore(o_restore), .o_restore_data_page_high(rs_pg),
    .o_restore_memory_addr_high(rs_ma), .o_restore_carry(rs_c), .o_restore_zero(rs_z),
    .o_flag_write(o_flag_write), .o_flag_write_data(o_flag_write_data),
    .o_audio_output_enable(o_audio_output_enable), .o_audio_request(o_audio_request),
    .i_port_a_pins(pins[3:0]), .i_port_b_pins(pins[7:4]), .i_port_e_pins(pins[11:8]));
  ihw_core_model u_core (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_pc_load(o_pc_load), .i_pc_load_addr(o_pc_load_addr),
    .i_core_clk_en(o_core_clk_en), .o_next_pc(i_next_pc), .o_data_page_high(i_data_page_high),
    .o_memory_addr_high(i_memory_addr_high), .o_carry_flag(i_carry_flag),
    .o_zero_flag(i_zero_flag), .o_exec_return_from_irq(i_exec_return_from_irq),
    .o_exec_halt(i_exec_halt));
////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic bit hit(input int sel);
    case (sel)
      0: return o_core_clk_en === 1'b1;
      1: return o_audio_request === 1'b1;
      2: return o_pc_load === 1'b1;
      default: return o_restore === 1'b1;
    endcase
  endfunction
  // pv keeps the core's next pc of the cycle before the hit
  task automatic wait_on(input int sel, input int lim, input bit must, output int k);
    k = 0;
    #1;
    while (k < lim && !hit(sel)) begin
      pv = i_next_pc;
      @(posedge i_mclk);
      #1;
      k++;
    end
    if (must && k >= lim) begin
      error_cnt++;
      close_out();
    end
  endtask
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge i_mclk);
      k++;
    end while (o_hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      error_cnt++;
      close_out();
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= a;
    i_hwrite <= wr;
    wait_rdy();
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    wait_rdy();
    rd = o_hrdata;
  endtask
////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge i_mclk);
    i_rst <= 1'b0;
    wait_on(0, 300, 1'b1, n);
    chk(n >= 64 && n <= 72, 1);
    bus(1'b0, 32'h00, 32'h0);
    chk(rd, 32'h2);
    chk(o_hresp, 1'b0);
    bus(1'b0, 32'h40, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 32'h24, 32'h1);
    wait_on(1, 100, 1'b1, n);
    chk(n >= 14 && n <= 19, 1);
    wait_on(2, 20, 1'b0, n);
    chk(n, 20);
    bus(1'b1, 32'h24, 32'h3);
    wait_on(2, 10, 1'b1, n);
    chk(n, 1);
    // later waits overwrite pv, so keep the next pc seen at entry
    pe = pv;
    chk(o_pc_load_addr, `IHW_VEC_IRQ);
    bus(1'b0, 32'h24, 32'h0);
    chk(rd, 32'h1);
    bus(1'b0, 32'h00, 32'h0);
    chk(rd, 32'h5);
    bus(1'b1, 32'h24, 32'h2);
    wait_on(2, 20, 1'b0, n);
    chk(n, 20);
    bus(1'b1, 32'h00, 32'h3);
    #1;
    chk({o_flag_write, o_flag_write_data, o_audio_request}, 4'hE);
    u_core.ret();
    wait_on(3, 5, 1'b1, n);
    chk(o_pc_load_addr, pe);
    chk({rs_pg, rs_ma, rs_c, rs_z}, 10'h296);
    bus(1'b0, 32'h24, 32'h0);
    chk(rd, 32'h2);
    for (int p = 0; p < 3; p++) begin
      bus(1'b1, 32'h24, 32'h1);
      u_core.halt();
      #1;
      chk({o_pc_load, o_pc_load_addr, o_core_clk_en, o_audio_output_enable}, 16'h8010);
      bus(1'b1, 32'h24, 32'h3);
      bus(1'b0, 32'h24, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, 32'h80, 32'h0);
      chk(rd, 32'h2);
      pins <= 12'h001 << (5 * p);
      wait_on(0, 200, 1'b1, n);
      chk(n >= 64 && n <= 76, 1);
      pins <= 12'h000;
    end
    u_core.halt();
    i_rst <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    #1;
    chk({o_pc_load, o_pc_load_addr}, 14'h2000);
    wait_on(0, 300, 1'b1, n);
    chk(n >= 64 && n <= 72, 1);
    close_out();
  end
endmodule
